// File: design/acc_cmd_if.sv
interface acc_cmd_if;
	logic wr_ier;
	logic wr_cr;
	logic [31:0] wdata;
	logic [31:0] ier;
	modport bus (output wr_ier, output wr_cr, output wdata, input ier);
	modport core (input wr_ier, input wr_cr, input wdata, output ier);
endinterface

// File: design/acc_ctrl.sv
`include "acc_regs.svh"
module acc_ctrl
(
	input  wire logic              i_clk_sys,     // System clock
	input  wire logic              i_arst_n,      // Async reset, active low
	input  wire logic              i_ce,          // Clock enable
	input  wire logic              i_psel,        // APB select
	input  wire logic              i_penable,     // APB enable
	input  wire logic              i_pwrite,      // APB direction
	input  wire logic [11:0]       i_paddr,       // APB byte address
	input  wire acc_pkg::acc_word_t i_pwdata,     // APB write data
	output acc_pkg::acc_word_t     o_prdata,      // APB read data
	output logic                   o_pready,      // APB ready
	output logic                   o_pslverr,     // APB error
	input  wire logic              i_watchdog_flag,      // Flag level
	input  wire logic              i_overrun_flag,       // Flag level
	input  wire logic              i_sequence_done_flag, // Flag level
	input  wire logic              i_conversion_done_flag, // Flag level
	input  wire logic              i_sampling_done_flag, // Flag level
	input  wire acc_pkg::acc_trig_e i_trigger_edge_select, // Trigger edge
	input  wire logic              i_continuous_mode,    // Continuous on
	input  wire logic              i_discontinuous_mode, // Discontinuous on
	input  wire logic              i_hw_trigger,  // Hardware trigger pulse
	input  wire logic              i_cal_done,    // Calibration finished
	input  wire logic              i_discard_done, // Abort finished
	input  wire logic              i_disable_pending, // Disable requested
	output logic                   o_converter_enable, // Enable level
	output logic                   o_calibrate,   // Calibration running
	output logic                   o_convert_go,  // Conversion start pulse
	output logic                   o_abort,       // Abort in progress
	output logic                   o_irq,         // Converter interrupt
	output logic                   o_event_irq    // Event status interrupt
);
	import acc_pkg::*;

	acc_cmd_if cmd ();
	logic [31:0] ier;
	logic        cal;
	logic        stp;
	logic        start;
	logic        en;
	logic [4:0]  flags;
	logic [4:0]  flags_q;
	logic [4:0]  evt;
	logic [4:0]  evt_mask;
	logic        wr;
	logic        rd;
	logic        sw_trig;
	logic        start_done;
	logic        mapped;
	acc_conv_e   state;

	// ****************************************
	// APB decode
	// ****************************************
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;
	assign mapped = (i_paddr == `ACC_OFS_IER) || (i_paddr == `ACC_OFS_CR)
		|| (i_paddr == `ACC_OFS_EVT) || (i_paddr == `ACC_OFS_MASK);
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign cmd.wr_ier = wr && (i_paddr == `ACC_OFS_IER);
	assign cmd.wr_cr = wr && (i_paddr == `ACC_OFS_CR);
	assign cmd.wdata = i_pwdata;
	assign ier = cmd.ier;

	acc_enable_bank u_bank
	(
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_ce      (i_ce),
		.cmd       (cmd.core)
	);

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_prdata <= 32'h00000000;
		else if (i_ce && i_psel && !i_penable && !i_pwrite)
		begin
			case (i_paddr)
				`ACC_OFS_IER:  o_prdata <= ier;
				`ACC_OFS_CR:   o_prdata <= {cal, 26'h0000000, stp, 1'b0,
					start, 1'b0, en};
				`ACC_OFS_EVT:  o_prdata <= {27'h0000000, evt};
				`ACC_OFS_MASK: o_prdata <= {27'h0000000, evt_mask};
				default:       o_prdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Converter interrupt
	// ****************************************
	assign flags = {i_watchdog_flag, i_overrun_flag, i_sequence_done_flag,
		i_conversion_done_flag, i_sampling_done_flag};
	assign o_irq = (i_watchdog_flag && ier[`ACC_BIT_WDG])
		|| (i_overrun_flag && ier[`ACC_BIT_OVRUN])
		|| (i_sequence_done_flag && ier[`ACC_BIT_SEQ])
		|| (i_conversion_done_flag && ier[`ACC_BIT_CONV])
		|| (i_sampling_done_flag && ier[`ACC_BIT_SAMP]);

	// ****************************************
	// Sticky event status, read clears, set wins
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			flags_q <= 5'h00;
		else if (i_ce)
			flags_q <= flags;
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			evt <= 5'h00;
		else if (i_ce)
		begin
			// Clear only what the read returned, so no event is lost
			if (rd && i_paddr == `ACC_OFS_EVT)
				evt <= (evt & ~o_prdata[4:0]) | (flags & ~flags_q);
			else
				evt <= evt | (flags & ~flags_q);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			evt_mask <= 5'h00;
		else if (i_ce && wr && i_paddr == `ACC_OFS_MASK)
			evt_mask <= i_pwdata[4:0];
	end

	assign o_event_irq = |(evt & evt_mask);

	// ****************************************
	// Command bits
	// ****************************************
	assign sw_trig = (i_trigger_edge_select == ACC_TRIG_SW);
	assign start_done = sw_trig && !i_continuous_mode
		&& ((!i_discontinuous_mode && i_sequence_done_flag)
		|| (i_discontinuous_mode && i_conversion_done_flag));

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			en <= 1'b0;
		else if (i_ce && cmd.wr_cr && i_pwdata[`ACC_BIT_EN])
			en <= 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cal <= 1'b0;
		else if (i_ce)
		begin
			if (cmd.wr_cr && i_pwdata[`ACC_BIT_CAL])
				cal <= 1'b1;
			else if (i_cal_done)
				cal <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			stp <= 1'b0;
		else if (i_ce)
		begin
			if (cmd.wr_cr && i_pwdata[`ACC_BIT_STP])
				stp <= 1'b1;
			else if (i_discard_done)
				stp <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			start <= 1'b0;
		else if (i_ce)
		begin
			if (cmd.wr_cr && i_pwdata[`ACC_BIT_START] && en
				&& !i_disable_pending)
				start <= 1'b1;
			else if (stp && i_discard_done)
				start <= 1'b0;
			else if (start_done && state == ACC_CONVERT)
				start <= 1'b0;
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state <= ACC_IDLE;
		else if (i_ce)
		begin
			case (state)
				ACC_IDLE:
					if (start)
						state <= sw_trig ? ACC_CONVERT : ACC_WAIT_TRIG;
				ACC_WAIT_TRIG:
					if (stp)
						state <= ACC_STOPPING;
					else if (i_hw_trigger)
						state <= ACC_CONVERT;
				ACC_CONVERT:
					if (stp)
						state <= ACC_STOPPING;
					else if (!start)
						state <= ACC_IDLE;
					else if (!sw_trig && i_conversion_done_flag)
						state <= ACC_WAIT_TRIG;
				ACC_STOPPING:
					if (!stp)
						state <= ACC_IDLE;
				default:
					state <= ACC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_convert_go <= 1'b0;
		else if (i_ce)
			o_convert_go <= !stp && ((state == ACC_IDLE && start && sw_trig)
				|| (state == ACC_WAIT_TRIG && i_hw_trigger));
	end

	assign o_converter_enable = en;
	assign o_calibrate = cal;
	assign o_abort = stp;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	watchdog_irq_a: assert property (
		i_watchdog_flag && ier[`ACC_BIT_WDG] |-> o_irq)
		else $error("watchdog irq missing");
	overrun_irq_a: assert property (
		i_overrun_flag && ier[`ACC_BIT_OVRUN] |-> o_irq)
		else $error("overrun irq missing");
	seq_irq_a: assert property (
		i_sequence_done_flag && ier[`ACC_BIT_SEQ] |-> o_irq)
		else $error("sequence irq missing");
	conv_irq_a: assert property (
		i_conversion_done_flag && ier[`ACC_BIT_CONV] |-> o_irq)
		else $error("conversion irq missing");
	samp_irq_a: assert property (
		i_sampling_done_flag && ier[`ACC_BIT_SAMP] |-> o_irq)
		else $error("sampling irq missing");
	irq_masked_a: assert property (
		(flags & {ier[7], ier[4:1]}) == 5'h00 |-> !o_irq)
		else $error("irq without enabled flag");
	cal_set_a: assert property (
		i_ce && cmd.wr_cr && i_pwdata[`ACC_BIT_CAL] |=> cal)
		else $error("calibrate not set");
	cal_clear_a: assert property (
		i_ce && cal && i_cal_done && !cmd.wr_cr |=> !cal)
		else $error("calibrate not cleared");
	stop_hold_a: assert property (
		stp && !i_discard_done |=> stp)
		else $error("stop dropped early");
	stop_clear_a: assert property (
		i_ce && stp && i_discard_done && !cmd.wr_cr |=> !stp)
		else $error("stop not cleared");
	start_stop_a: assert property (
		i_ce && start && stp && i_discard_done && !cmd.wr_cr
		|=> !start && !stp)
		else $error("start not cleared with stop");
	start_hold_a: assert property (
		start && !stp && !(sw_trig && !i_continuous_mode) |=> start)
		else $error("start cleared without stop");
	seq_clear_a: assert property (
		i_ce && state == ACC_CONVERT && sw_trig && !i_continuous_mode
		&& !i_discontinuous_mode && i_sequence_done_flag
		&& !cmd.wr_cr |=> !start)
		else $error("start not cleared at sequence end");
	disc_clear_a: assert property (
		i_ce && state == ACC_CONVERT && sw_trig && !i_continuous_mode
		&& i_discontinuous_mode && i_conversion_done_flag
		&& !cmd.wr_cr |=> !start)
		else $error("start not cleared at conversion end");
	start_refuse_a: assert property (
		cmd.wr_cr && i_pwdata[`ACC_BIT_START] && !start
		&& (!en || i_disable_pending) |=> !start)
		else $error("start set while refused");
	reserved_a: assert property (
		$past(i_ce) && $past(i_psel) && !$past(i_penable)
		&& !$past(i_pwrite) && $past(i_paddr) == `ACC_OFS_CR
		|-> (o_prdata & 32'h7fffffea) == 32'h00000000)
		else $error("reserved bits nonzero");
	sw_go_a: assert property (
		i_ce && state == ACC_IDLE && start && sw_trig && !stp
		|=> o_convert_go)
		else $error("no sw start");
	hw_wait_a: assert property (
		i_ce && state == ACC_WAIT_TRIG && !i_hw_trigger
		|=> !o_convert_go)
		else $error("start without hardware trigger");
	ce_freeze_a: assert property (
		!i_ce |=> $stable(start) && $stable(stp) && $stable(cal)
		&& $stable(ier) && $stable(o_prdata))
		else $error("state changed while clock enable low");

	cover_irq_c: cover property (!o_irq ##1 o_irq);
	cover_cal_c: cover property (cal ##[1:20] !cal);
	cover_stop_c: cover property (start && stp ##[1:20] !start);
	cover_hw_c: cover property (state == ACC_WAIT_TRIG ##1 o_convert_go);
	cover_ce_c: cover property (!i_ce ##1 i_ce);
endmodule

// File: design/acc_enable_bank.sv
`include "acc_regs.svh"
module acc_enable_bank
(
	input  wire logic i_clk_sys,    // System clock
	input  wire logic i_arst_n,     // Async reset, active low
	input  wire logic i_ce,         // Clock enable
	acc_cmd_if.core   cmd           // Write strobes and enable readback
);
	logic [31:0] ier;

	// ****************************************
	// Interrupt enable register
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ier <= `ACC_IER_RESET;
		else if (i_ce && cmd.wr_ier)
			ier <= cmd.wdata & `ACC_IER_MASK;
	end

	assign cmd.ier = ier;
endmodule

// File: design/acc_pkg.sv
package acc_pkg;
	typedef logic [31:0] acc_word_t;
	typedef enum logic [1:0]
	{
		ACC_TRIG_SW,
		ACC_TRIG_RISE,
		ACC_TRIG_FALL,
		ACC_TRIG_BOTH
	} acc_trig_e;
	typedef enum
	{
		ACC_IDLE,
		ACC_WAIT_TRIG,
		ACC_CONVERT,
		ACC_STOPPING
	} acc_conv_e;
endpackage

// File: design/acc_regs.svh
// Contract
// - Watchdog flag with enable bit 7 raises the converter interrupt.
// - Overrun flag with enable bit 4 raises the interrupt; enable 0 masks.
// - Sequence-done flag with enable bit 3 raises the interrupt.
// - Conversion-done flag with enable bit 2 raises the interrupt.
// - Sampling-done flag with enable bit 1 raises the interrupt.
// - Writing 1 to bit 31 calibrates; reads 1 until calibration completes.
// - Writing 1 to bit 4 aborts conversion; reads 1 until discard done.
// - Start bit 2 converts now on software trigger, else awaits trigger.
// - Single mode with software trigger: start clears at sequence done.
// - Discontinuous with software trigger: start clears at conversion done.
// - Otherwise start clears only with stop completion, same cycle.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFS_IER     12'h004
`define ACC_OFS_CR      12'h008
`define ACC_OFS_EVT     12'h00c
`define ACC_OFS_MASK    12'h010
`define ACC_BIT_WDG     7
`define ACC_BIT_OVRUN   4
`define ACC_BIT_SEQ     3
`define ACC_BIT_CONV    2
`define ACC_BIT_SAMP    1
`define ACC_BIT_CAL     31
`define ACC_BIT_STP     4
`define ACC_BIT_START   2
`define ACC_BIT_EN      0
`define ACC_IER_MASK    32'h0000009e
`define ACC_IER_RESET   32'h00000000
`define ACC_CR_RESET    32'h00000000
`define ACC_EVT_MASK    32'h0000001f
`endif

// File: verif/tb_adc_irq_enable_and_command_ctrl.sv
`include "acc_regs.svh"
module tb_adc_irq_enable_and_command_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import acc_pkg::*;
	logic        clk, rst_n, ce, psel, pen, pwr, cmode, disc, dpend;
	logic        pready, pslverr, en, cal, go, abort, irq, evirq, err;
	logic [11:0] addr;
	logic [4:0]  flg;
	logic [2:0]  ctl;
	acc_word_t   wd, rd, prdata, v;
	acc_trig_e   trig;
	int          errors, check_count;
	acc_word_t   one [5] = '{32'h80, 32'h10, 32'h08, 32'h04, 32'h02};

	acc_ctrl acc_ctrl_i (.i_clk_sys(clk), .i_arst_n(rst_n), .i_ce(ce),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
		.i_pwdata(wd), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_watchdog_flag(flg[4]),
		.i_overrun_flag(flg[3]), .i_sequence_done_flag(flg[2]),
		.i_conversion_done_flag(flg[1]), .i_sampling_done_flag(flg[0]),
		.i_trigger_edge_select(trig), .i_continuous_mode(cmode),
		.i_discontinuous_mode(disc), .i_hw_trigger(ctl[0]),
		.i_cal_done(ctl[1]), .i_discard_done(ctl[2]),
		.i_disable_pending(dpend), .o_converter_enable(en),
		.o_calibrate(cal), .o_convert_go(go), .o_abort(abort),
		.o_irq(irq), .o_event_irq(evirq));

	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// ******************
	// Tasks
	// ******************
	task automatic chk_w(string n, acc_word_t e, acc_word_t g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_b(string n, logic e, logic g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic apb(logic w, logic [11:0] a, acc_word_t d);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
	endtask

	task automatic rdreg(logic [11:0] a, acc_word_t e, string n);
		apb(0, a, 0);
		chk_w(n, e, rd);
	endtask

	task automatic pulse(int k);
		@(posedge clk);
		ctl[k] <= 1;
		@(posedge clk);
		ctl[k] <= 0;
	endtask

	task automatic fpulse(logic [4:0] f);
		@(posedge clk);
		flg <= f;
		@(posedge clk);
		flg <= 0;
	endtask

	task automatic wait_go(output logic s);
		s = 0;
		repeat (8)
		begin
			@(negedge clk);
			if (go === 1'b1)
				s = 1;
		end
	endtask

	function automatic logic exp_irq(acc_word_t ie, logic [4:0] f);
		return |({ie[7], ie[4], ie[3], ie[2], ie[1]} & f);
	endfunction

	task automatic tend(string n);
		$display("test %s done", n);
	endtask

	task automatic conv(logic c, logic d, acc_trig_e t);
		logic s, ss;
		ss = !c && t == ACC_TRIG_SW;
		cmode <= c;
		disc <= d;
		trig <= t;
		apb(1, `ACC_OFS_CR, 32'h4);
		if (t != ACC_TRIG_SW)
		begin
			wait_go(s);
			chk_b("go_early", 0, s);
			pulse(0);
		end
		wait_go(s);
		chk_b("go", 1, s);
		fpulse(5'h04);
		rdreg(`ACC_OFS_CR, {29'h0, !(ss && !d), 2'b01}, "st_seq");
		fpulse(5'h02);
		rdreg(`ACC_OFS_CR, {29'h0, !ss, 2'b01}, "st_conv");
		apb(1, `ACC_OFS_CR, 32'h10);
		rdreg(`ACC_OFS_CR, {27'h0, 2'b10, !ss, 2'b01}, "stop_on");
		chk_b("abort", 1, abort);
		pulse(2);
		rdreg(`ACC_OFS_CR, 32'h1, "stop_done");
		tend("convert");
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		errors++;
		report_and_stop();
	end

	// ******************
	// Tests
	// ******************
	initial
	begin
		logic e0, e1;
		{psel, pen, pwr, cmode, disc, dpend, rst_n} = 0;
		ce = 1;
		{addr, flg, ctl, wd} = 0;
		trig = ACC_TRIG_SW;
		void'($urandom(78357));
		repeat (5) @(posedge clk);
		rst_n <= 1;
		rdreg(`ACC_OFS_IER, 0, "ier_rst");
		rdreg(`ACC_OFS_CR, 0, "cr_rst");
		chk_b("pready", 1, pready);
		apb(0, 12'h020, 32'hffffffff);
		chk_b("unmapped_err", 1, err);
		chk_w("unmapped_rd", 0, rd);
		tend("reset");
		// Single sources on and masked, then random pairs
		for (int i = 0; i < 40; i++)
		begin
			v = (i < 5) ? one[i] : (i < 10) ? ~one[i - 5] : $urandom;
			apb(1, `ACC_OFS_IER, v);
			flg <= (i < 10) ? 5'h10 >> (i % 5) : 5'($urandom);
			rdreg(`ACC_OFS_IER, v & 32'h9e, "ier_rw");
			@(negedge clk);
			chk_b("irq", exp_irq(v, flg), irq);
		end
		flg <= 0;
		apb(1, `ACC_OFS_IER, 0);
		tend("irq");
		apb(0, `ACC_OFS_EVT, 0);
		apb(1, `ACC_OFS_MASK, 32'h1f);
		fpulse(5'h04);
		@(negedge clk);
		e1 = evirq;
		apb(1, `ACC_OFS_MASK, 0);
		@(negedge clk);
		e0 = evirq;
		chk_b("evt_irq_on", 1, e1);
		chk_b("evt_irq_off", 0, e0);
		rdreg(`ACC_OFS_EVT, 32'h4, "evt_set");
		rdreg(`ACC_OFS_EVT, 32'h0, "evt_clr");
		tend("event");
		apb(1, `ACC_OFS_CR, 32'h4);
		rdreg(`ACC_OFS_CR, 0, "start_off");
		apb(1, `ACC_OFS_CR, 32'h1);
		dpend <= 1;
		apb(1, `ACC_OFS_CR, 32'h4);
		rdreg(`ACC_OFS_CR, 32'h1, "start_pend");
		chk_b("enable", 1, en);
		dpend <= 0;
		apb(1, `ACC_OFS_CR, 32'h7fffffea);
		rdreg(`ACC_OFS_CR, 32'h1, "cr_resv");
		apb(1, `ACC_OFS_CR, 32'h80000000);
		rdreg(`ACC_OFS_CR, 32'h80000001, "cal_on");
		apb(1, `ACC_OFS_CR, 0);
		rdreg(`ACC_OFS_CR, 32'h80000001, "cal_w0");
		chk_b("cal", 1, cal);
		pulse(1);
		repeat (2) @(posedge clk);
		rdreg(`ACC_OFS_CR, 32'h1, "cal_done");
		tend("command");
		conv(0, 0, ACC_TRIG_SW);
		conv(0, 1, ACC_TRIG_SW);
		conv(1, 0, ACC_TRIG_SW);
		conv(0, 0, ACC_TRIG_RISE);
		conv(0, 1, ACC_TRIG_FALL);
		conv(1, 1, ACC_TRIG_BOTH);
		ce <= 0;
		apb(1, `ACC_OFS_IER, 32'h9e);
		ce <= 1;
		rdreg(`ACC_OFS_IER, 0, "ce_frozen");
		apb(1, `ACC_OFS_IER, 32'h9e);
		rdreg(`ACC_OFS_IER, 32'h9e, "ce_live");
		tend("clock_enable");
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		rdreg(`ACC_OFS_IER, 0, "ier_rst2");
		rdreg(`ACC_OFS_CR, 0, "cr_rst2");
		tend("reset_again");
		report_and_stop();
	end
endmodule
